// file: include/ppc_pkg.sv
/*
 package for the port pin configuration block: register offsets, reset values,
 mode encodings and field layout. assumes a 32-bit apb slave, one word per register.
*/
package ppc_pkg;
    // ----------------------------------------
    // register word indices
    // ----------------------------------------
    // printed offsets 0xf6 and 0xfb are not multiples of four: they are indices
    localparam logic [7:0] PPC_IDX_PULLUP = 8'hF6;
    localparam logic [7:0] PPC_IDX_P5H = 8'hFB;
    localparam logic [7:0] PPC_IDX_EDGE = 8'hF8;
    localparam logic [7:0] PPC_IDX_P4H = 8'hF9;
    localparam logic [7:0] PPC_IDX_P4L = 8'hFA;
    localparam logic [7:0] PPC_IDX_IRQ_EN = 8'hF7;
    localparam logic [7:0] PPC_IDX_IRQ_STAT = 8'hFC;
    localparam logic [7:0] PPC_IDX_IRQ_MASK = 8'hFD;
    localparam logic [7:0] PPC_IDX_PIN_IN = 8'hFE;
    localparam int PPC_ADDR_W = 10;

    // ----------------------------------------
    // reset values and widths
    // ----------------------------------------
    localparam logic [7:0] PPC_RST_BYTE = 8'h00;
    localparam logic [1:0] PPC_RST_PAIR = 2'h0;
    localparam int PPC_MODE_W = 2;
    localparam int PPC_NIBBLE = 4;
    localparam int PPC_MODE_PINS = 12;
    localparam int PPC_EXT_PINS = 2;

    // ----------------------------------------
    // pin modes
    // ----------------------------------------
    typedef enum logic [1:0] {
        PPC_MODE_INPUT = 2'b00,
        PPC_MODE_PUSH_PULL = 2'b01,
        PPC_MODE_OPEN_DRAIN = 2'b10,
        PPC_MODE_INPUT_PULLUP = 2'b11
    } ppc_mode_t;
endpackage

// file: hw/ppc_pin_mode.sv
/*
 one general port pin: decodes its 2-bit mode into drive, enable and pull-up.
 assumes the pin pad resolves the wire from out, enable and pull-up.
*/
`timescale 1ns/1ps
module ppc_pin_mode
    import ppc_pkg::*;
(
    // mode and data
    input wire logic [1:0] mode_i,
    input wire logic data_i,
    // pad controls
    output logic pad_out_o,
    output logic pad_oe_n_o,
    output logic pad_pullup_o
);
    always_comb begin
        pad_out_o = data_i;
        pad_oe_n_o = 1'b1;
        pad_pullup_o = 1'b0;
        case (mode_i)
            PPC_MODE_INPUT: begin
                pad_oe_n_o = 1'b1;
            end
            PPC_MODE_INPUT_PULLUP: begin
                pad_pullup_o = 1'b1;
            end
            PPC_MODE_PUSH_PULL: begin
                pad_oe_n_o = 1'b0;
            end
            PPC_MODE_OPEN_DRAIN: begin
                // drives only a low, releases the wire for a high
                pad_out_o = 1'b0;
                pad_oe_n_o = data_i;
            end
            default: begin
                pad_oe_n_o = 1'b1;
            end
        endcase
    end
endmodule

// file: hw/ppc_edge_detect.sv
/*
 synchroniser and selectable edge detector for one external interrupt pin.
 assumes the pin is asynchronous to CLK_I.
*/
`timescale 1ns/1ps
module ppc_edge_detect (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // pin and control
    input wire logic pin_i,
    input wire logic rising_i,
    output logic edge_o
);
    logic sync_a;
    logic sync_b;
    logic last;
    logic next_edge;

    always_comb begin
        if (rising_i) begin
            next_edge = sync_b & ~last;
        end else begin
            next_edge = ~sync_b & last;
        end
    end

    // first stage read only by the second: keeps metastability out of the compare
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            last <= 1'b0;
            edge_o <= 1'b0;
        end else begin
            sync_a <= pin_i;
            sync_b <= sync_a;
            last <= sync_b;
            edge_o <= next_edge;
        end
    end
endmodule

// file: hw/ppc_top.sv
/*
 port pin configuration block: port-3 pull-ups and interrupt edge selection,
 2-bit mode fields for port 4 and upper port 5, edge interrupts with sticky status.
 assumes an apb master on CLK_I and pads that resolve out/enable/pull-up.
*/
// Decided for this implementation: the APB slave port.
// Notes on behaviour
// - pull-up register bit 0 enables pin zero pull-up
// - pull-up register bit 1 enables pin one pull-up
// - edge bit 0: 0 falling, 1 rising
// - edge bit 1 same for pin one
// - mode 00 input, 11 input with pull-up
// - mode 01 push-pull, 10 open-drain low only
// - port-4 registers hold four 2-bit fields each
`timescale 1ns/1ps
module ppc_top
    import ppc_pkg::*;
(
    // clock and reset
    input wire logic CLK_I,
    input wire logic RESET_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [PPC_ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // port-3 external interrupt pins
    input wire logic [PPC_EXT_PINS-1:0] PORT3_PIN_I,
    output logic [PPC_EXT_PINS-1:0] PORT3_PULLUP_O,
    // port 4 pins 7..0 then port 5 pins 7..4 at indices 11..8
    input wire logic [PPC_MODE_PINS-1:0] PORT_DATA_I,
    output logic [PPC_MODE_PINS-1:0] PORT_OUT_O,
    output logic [PPC_MODE_PINS-1:0] PORT_OE_N_O,
    output logic [PPC_MODE_PINS-1:0] PORT_PULLUP_O,
    // interrupt
    output logic IRQ_O
);
    // ----------------------------------------
    // register state
    // ----------------------------------------
    logic [1:0] port3_pullup_enable;
    logic [1:0] port3_edge_select;
    logic [1:0] irq_enable;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [7:0] port4_high_mode_control;
    logic [7:0] port4_low_mode_control;
    logic [7:0] port5_high_mode_control;
    logic [1:0] next_pullup;
    logic [1:0] next_edge_sel;
    logic [1:0] next_irq_enable;
    logic [1:0] next_irq_status;
    logic [1:0] next_irq_mask;
    logic [1:0] cleared_status;
    logic [7:0] next_p4h;
    logic [7:0] next_p4l;
    logic [7:0] next_p5h;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_irq;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    logic access;
    logic wr;
    logic [7:0] idx;
    logic aligned;
    logic mapped;
    logic [7:0] wbyte;
    logic [1:0] edge_hit;
    logic [2*PPC_MODE_PINS-1:0] mode_vec;
    logic [PPC_MODE_PINS-1:0] pin_sync_a;
    logic [PPC_MODE_PINS-1:0] pin_sync_b;
    logic [1:0] p3_sync_a;
    logic [1:0] p3_sync_b;

    assign access = PSEL_I & PENABLE_I & ~PREADY_O;
    assign idx = PADDR_I[PPC_ADDR_W-1:2];
    assign aligned = (PADDR_I[1:0] == 2'b00);
    assign wr = access & PWRITE_I & PSTRB_I[0] & aligned;
    assign wbyte = PWDATA_I[7:0];
    // pin n of a nibble takes field [2n+1:2n]
    assign mode_vec = {port5_high_mode_control, port4_high_mode_control,
        port4_low_mode_control};

    // anything not listed, or not word aligned, is refused with an error
    always_comb begin
        case (idx)
            PPC_IDX_PULLUP, PPC_IDX_P5H, PPC_IDX_EDGE, PPC_IDX_P4H, PPC_IDX_P4L,
            PPC_IDX_IRQ_EN, PPC_IDX_IRQ_STAT, PPC_IDX_IRQ_MASK, PPC_IDX_PIN_IN: begin
                mapped = aligned;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // register next values
    // ----------------------------------------
    always_comb begin
        next_pullup = port3_pullup_enable;
        next_edge_sel = port3_edge_select;
        next_irq_enable = irq_enable;
        next_irq_mask = irq_mask;
        next_p4h = port4_high_mode_control;
        next_p4l = port4_low_mode_control;
        next_p5h = port5_high_mode_control;
        cleared_status = irq_status;
        if (wr && mapped) begin
            case (idx)
                PPC_IDX_PULLUP: begin
                    next_pullup = wbyte[1:0];
                end
                PPC_IDX_EDGE: begin
                    next_edge_sel = wbyte[1:0];
                end
                PPC_IDX_IRQ_EN: begin
                    next_irq_enable = wbyte[1:0];
                end
                PPC_IDX_IRQ_MASK: begin
                    next_irq_mask = wbyte[1:0];
                end
                PPC_IDX_IRQ_STAT: begin
                    cleared_status = irq_status & ~wbyte[1:0];
                end
                PPC_IDX_P4H: begin
                    next_p4h = wbyte;
                end
                PPC_IDX_P4L: begin
                    next_p4l = wbyte;
                end
                PPC_IDX_P5H: begin
                    next_p5h = wbyte;
                end
                default: begin
                    next_p4l = port4_low_mode_control;
                end
            endcase
        end
    end

    // ----------------------------------------
    // interrupt next values
    // ----------------------------------------
    // set wins: an edge in the cycle of a write-one clear keeps its bit, so a
    // clear-then-read sequence in software never loses an event
    always_comb begin
        next_irq_status = cleared_status | (edge_hit & irq_enable);
        // the line follows the next register image, one edge after the cause
        next_irq = |(next_irq_status & next_irq_mask);
    end

    // ----------------------------------------
    // apb answer: one wait state, ready in the second access cycle after setup
    // ----------------------------------------
    // the registered answer costs a wait state but keeps the decode off PRDATA_O
    // writes to the read-only pin image are accepted and ignored
    always_comb begin
        next_pready = access;
        next_pslverr = access & ~mapped;
        next_prdata = 32'h0000_0000;
        if (access && !PWRITE_I && mapped) begin
            case (idx)
                PPC_IDX_PULLUP: next_prdata[1:0] = port3_pullup_enable;
                PPC_IDX_EDGE: next_prdata[1:0] = port3_edge_select;
                PPC_IDX_IRQ_EN: next_prdata[1:0] = irq_enable;
                PPC_IDX_IRQ_STAT: next_prdata[1:0] = irq_status;
                PPC_IDX_IRQ_MASK: next_prdata[1:0] = irq_mask;
                PPC_IDX_P4H: next_prdata[7:0] = port4_high_mode_control;
                PPC_IDX_P4L: next_prdata[7:0] = port4_low_mode_control;
                PPC_IDX_P5H: next_prdata[7:0] = port5_high_mode_control;
                PPC_IDX_PIN_IN: next_prdata[15:0] = {2'b00, p3_sync_b, pin_sync_b};
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // register file
    // ----------------------------------------
    // the port-3 pull-up pads take the next value, so they move with the register
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            port3_pullup_enable <= PPC_RST_PAIR;
            port3_edge_select <= PPC_RST_PAIR;
            irq_enable <= PPC_RST_PAIR;
            irq_mask <= PPC_RST_PAIR;
            port4_high_mode_control <= PPC_RST_BYTE;
            port4_low_mode_control <= PPC_RST_BYTE;
            port5_high_mode_control <= PPC_RST_BYTE;
            PORT3_PULLUP_O <= PPC_RST_PAIR;
        end else begin
            port3_pullup_enable <= next_pullup;
            port3_edge_select <= next_edge_sel;
            irq_enable <= next_irq_enable;
            irq_mask <= next_irq_mask;
            port4_high_mode_control <= next_p4h;
            port4_low_mode_control <= next_p4l;
            port5_high_mode_control <= next_p5h;
            PORT3_PULLUP_O <= next_pullup;
        end
    end

    // ----------------------------------------
    // interrupt state
    // ----------------------------------------
    // IRQ_O comes from the next image so it rises in the same edge as its status bit
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            irq_status <= PPC_RST_PAIR;
            IRQ_O <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            IRQ_O <= next_irq;
        end
    end

    // ----------------------------------------
    // apb answer registers
    // ----------------------------------------
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            PRDATA_O <= 32'h0000_0000;
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
        end else begin
            PRDATA_O <= next_prdata;
            PREADY_O <= next_pready;
            PSLVERR_O <= next_pslverr;
        end
    end

    // ----------------------------------------
    // pin level synchronisers
    // ----------------------------------------
    // read-back only: the first stage feeds nothing but the second, so a
    // metastable sample never reaches the bus
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            pin_sync_a <= '0;
            pin_sync_b <= '0;
            p3_sync_a <= PPC_RST_PAIR;
            p3_sync_b <= PPC_RST_PAIR;
        end else begin
            pin_sync_a <= PORT_DATA_I;
            pin_sync_b <= pin_sync_a;
            p3_sync_a <= PORT3_PIN_I;
            p3_sync_b <= p3_sync_a;
        end
    end

    // ----------------------------------------
    // per-pin logic
    // ----------------------------------------
    genvar g;
    generate
        // each detector carries its own two-stage synchroniser
        for (g = 0; g < PPC_EXT_PINS; g++) begin : g_ext
            ppc_edge_detect u_edge (
                .clk_i(CLK_I),
                .reset_i(RESET_I),
                .pin_i(PORT3_PIN_I[g]),
                .rising_i(port3_edge_select[g]),
                .edge_o(edge_hit[g])
            );
        end
        for (g = 0; g < PPC_MODE_PINS; g++) begin : g_pin
            logic pad_out;
            logic pad_oe_n;
            logic pad_pu;
            // no output data register lives here: push-pull drives a one,
            // open-drain pulls low, and the other modes leave the output at zero
            // pad controls are registered below so the pins never see decode glitches
            ppc_pin_mode u_mode (
                .mode_i(mode_vec[2*g+1:2*g]),
                .data_i(mode_vec[2*g+1:2*g] == PPC_MODE_PUSH_PULL),
                .pad_out_o(pad_out),
                .pad_oe_n_o(pad_oe_n),
                .pad_pullup_o(pad_pu)
            );
            always_ff @(posedge CLK_I) begin
                if (RESET_I) begin
                    PORT_OUT_O[g] <= 1'b0;
                    PORT_OE_N_O[g] <= 1'b1;
                    PORT_PULLUP_O[g] <= 1'b0;
                end else begin
                    PORT_OUT_O[g] <= pad_out;
                    PORT_OE_N_O[g] <= pad_oe_n;
                    PORT_PULLUP_O[g] <= pad_pu;
                end
            end
        end
    endgenerate
endmodule

// file: testbench/ppc_checker.sv
/* checker: bus timing, pad and interrupt relations at the ppc_top ports.
   assumes one clock CLK_I and a synchronous active-high RESET_I. */
`timescale 1ns/1ps
module ppc_checker
    import ppc_pkg::*;
(
    // all inputs, named as the top ports
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [PPC_ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic [PPC_EXT_PINS-1:0] PORT3_PIN_I,
    input wire logic [PPC_EXT_PINS-1:0] PORT3_PULLUP_O,
    input wire logic [PPC_MODE_PINS-1:0] PORT_OE_N_O,
    input wire logic [PPC_MODE_PINS-1:0] PORT_PULLUP_O,
    input wire logic IRQ_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    logic take;
    logic [3:0] quiet;
    assign take = PSEL_I && PENABLE_I && !PREADY_O;
    // cycles since the last bus access or pin change, saturating
    always_ff @(posedge CLK_I) begin
        if (RESET_I || PSEL_I || !$stable(PORT3_PIN_I)) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hF) begin
            quiet <= quiet + 4'h1;
        end
    end
    property p_ready; take |=> PREADY_O ##1 !PREADY_O; endproperty
    a_ready: assert property (p_ready) else $error("ready not one cycle after access");
    property p_idle; !PSEL_I |=> !PREADY_O; endproperty
    a_idle: assert property (p_idle) else $error("ready without select");
    property p_err; take && PADDR_I[1:0] != 2'h0 |=> PSLVERR_O; endproperty
    a_err: assert property (p_err) else $error("misaligned access not refused");
    // the pin image is the one register wider than a byte
    property p_upper;
        PREADY_O |-> PRDATA_O[31:16] == 16'h0000
            && (PADDR_I == {PPC_IDX_PIN_IN, 2'h0} || PRDATA_O[15:8] == 8'h00);
    endproperty
    a_upper: assert property (p_upper) else $error("read data upper bits set");
    property p_pullup;
        take && PWRITE_I && PSTRB_I[0] && PADDR_I == {PPC_IDX_PULLUP, 2'h0}
            |-> ##2 PORT3_PULLUP_O == $past(PWDATA_I[1:0], 2);
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up outputs miss write");
    property p_pad_hold; quiet > 4'h2 |-> $stable(PORT_OE_N_O) && $stable(PORT_PULLUP_O); endproperty
    a_pad_hold: assert property (p_pad_hold) else $error("pads moved without write");
    property p_oe_pull; (~PORT_OE_N_O & PORT_PULLUP_O) == '0; endproperty
    a_oe_pull: assert property (p_oe_pull) else $error("pull-up on driven pin");
    property p_irq_edge; $rose(IRQ_O) |-> quiet < 4'h7; endproperty
    a_irq_edge: assert property (p_irq_edge) else $error("interrupt without cause");
    c_write: cover property (take && PWRITE_I);
    c_err: cover property (PSLVERR_O);
    c_irq: cover property ($rose(IRQ_O));
endmodule
bind ppc_top ppc_checker u_chk (.*);

// file: testbench/ppc_board.sv
/* board model: resolves the port pads and drives the port-3 pins.
   assumes pads follow out, active-low enable and pull-up of ppc_top. */
`timescale 1ns/1ps
module ppc_board
    import ppc_pkg::*;
(
    // pad controls and commanded levels
    input wire logic clk_i,
    input wire logic [PPC_MODE_PINS-1:0] out_i,
    input wire logic [PPC_MODE_PINS-1:0] oe_n_i,
    input wire logic [PPC_MODE_PINS-1:0] pullup_i,
    input wire logic [PPC_EXT_PINS-1:0] p3_pullup_i,
    input wire logic [PPC_EXT_PINS-1:0] p3_drive_i,
    input wire logic [PPC_EXT_PINS-1:0] p3_level_i,
    // resolved wires
    output logic [PPC_MODE_PINS-1:0] data_o,
    output logic [PPC_EXT_PINS-1:0] pin_o
);
    logic toggle = 1'b0;
    // an undriven line without pull-up wanders so a stale value never passes
    always @(posedge clk_i) toggle <= ~toggle;
    always_comb begin
        for (int i = 0; i < PPC_MODE_PINS; i++) begin
            data_o[i] = !oe_n_i[i] ? out_i[i] : (pullup_i[i] | toggle);
        end
        pin_o = (p3_drive_i & p3_level_i) | (~p3_drive_i & (p3_pullup_i | {2{toggle}}));
    end
endmodule

// file: testbench/tb.sv
/* self-checking bench for ppc_top with the board model on its pins.
   assumes ppc_pkg and the design files are compiled first. */
`timescale 1ns/1ps
module tb;
    import ppc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, irq, er;
    logic [PPC_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic [1:0] p3_pin, p3_pu, p3_drv = 2'h3, p3_lvl = 2'h0;
    logic [11:0] pdata, pout, poe_n, ppu;
    int error_cnt = 0, checked = 0, cycles = 0;
    ppc_top DUT (.CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .PORT3_PIN_I(p3_pin), .PORT3_PULLUP_O(p3_pu),
        .PORT_DATA_I(pdata), .PORT_OUT_O(pout), .PORT_OE_N_O(poe_n), .PORT_PULLUP_O(ppu),
        .IRQ_O(irq));
    ppc_board u_board (.clk_i(clk), .out_i(pout), .oe_n_i(poe_n), .pullup_i(ppu),
        .p3_pullup_i(p3_pu), .p3_drive_i(p3_drv), .p3_level_i(p3_lvl), .data_o(pdata),
        .pin_o(p3_pin));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // --------------------------------
    // bus and compare helpers
    // --------------------------------
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (exp !== got) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [1:0] lo,
        input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= {idx, lo};
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, 2'h0, {24'h00_0000, d});
    endtask
    task automatic rreg(input logic [7:0] idx, input logic [7:0] exp, input string what);
        apb(1'b0, idx, 2'h0, 32'h0000_0000);
        chk(what, {24'h00_0000, exp}, rd);
    endtask
    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic t_reset();
        rreg(PPC_IDX_PULLUP, 8'h00, "pullup reg");
        rreg(PPC_IDX_EDGE, 8'h00, "edge reg");
        rreg(PPC_IDX_P4H, 8'h00, "p4 high");
        rreg(PPC_IDX_P4L, 8'h00, "p4 low");
        rreg(PPC_IDX_P5H, 8'h00, "p5 high");
        chk("oe_n", 32'h0000_0FFF, {20'h0_0000, poe_n});
    endtask
    task automatic t_errors();
        apb(1'b0, 8'h00, 2'h0, 32'h0000_0000);
        chk("unmapped err", 32'h1, {31'h0, er});
        apb(1'b1, PPC_IDX_P5H, 2'h1, 32'h0000_00FF);
        chk("misaligned err", 32'h1, {31'h0, er});
        pstrb <= 4'h0;
        wreg(PPC_IDX_P5H, 8'hFF);
        pstrb <= 4'hF;
        rreg(PPC_IDX_P5H, 8'h00, "no write");
    endtask
    task automatic t_pullup();
        wreg(PPC_IDX_PULLUP, 8'h01);
        rreg(PPC_IDX_PULLUP, 8'h01, "pullup zero");
        chk("pullup pins", 32'h1, {30'h0, p3_pu});
        wreg(PPC_IDX_PULLUP, 8'h02);
        rreg(PPC_IDX_PULLUP, 8'h02, "pullup one");
        chk("pullup pins", 32'h2, {30'h0, p3_pu});
    endtask
    task automatic t_modes();
        logic [1:0] m;
        for (int i = 0; i < 4; i++) begin
            m = i[1:0];
            wreg(PPC_IDX_P4L, {4{m}});
            wreg(PPC_IDX_P4H, {4{m}});
            wreg(PPC_IDX_P5H, {4{m}});
            @(posedge clk);
            chk("oe_n", (m == 2'h1 || m == 2'h2) ? 32'h0 : 32'hFFF, {20'h0, poe_n});
            chk("pullup", (m == 2'h3) ? 32'hFFF : 32'h0, {20'h0, ppu});
            chk("out", (m == 2'h1) ? 32'hFFF : 32'h0, {20'h0, pout});
            if (m != 2'h0) begin
                apb(1'b0, PPC_IDX_PIN_IN, 2'h0, 32'h0000_0000);
                chk("pin level", (m == 2'h2) ? 32'h0 : 32'hFFF, {20'h0, rd[11:0]});
            end
        end
    endtask
    task automatic t_order();
        wreg(PPC_IDX_P4L, 8'h1B);
        wreg(PPC_IDX_P4H, 8'hE4);
        wreg(PPC_IDX_P5H, 8'h1B);
        @(posedge clk);
        chk("field oe_n", 32'h999, {20'h0, poe_n});
        chk("field pullup", 32'h181, {20'h0, ppu});
    endtask
    task automatic t_irq();
        wreg(PPC_IDX_IRQ_EN, 8'h03);
        wreg(PPC_IDX_IRQ_MASK, 8'h03);
        for (int s = 0; s < 2; s++) begin
            p3_lvl <= {2{s[0]}};
            wreg(PPC_IDX_EDGE, {6'h0, {2{s[0]}}});
            rreg(PPC_IDX_EDGE, {6'h0, {2{s[0]}}}, "edge reg");
            wreg(PPC_IDX_IRQ_STAT, 8'h03);
            p3_lvl <= {2{~s[0]}};
            repeat (8) @(posedge clk);
            rreg(PPC_IDX_IRQ_STAT, 8'h00, "wrong edge");
            p3_lvl <= {2{s[0]}};
            repeat (8) @(posedge clk);
            rreg(PPC_IDX_IRQ_STAT, 8'h03, "edge seen");
            chk("irq high", 32'h1, {31'h0, irq});
            wreg(PPC_IDX_IRQ_MASK, 8'h00);
            @(posedge clk);
            chk("irq masked", 32'h0, {31'h0, irq});
            wreg(PPC_IDX_IRQ_MASK, 8'h03);
            wreg(PPC_IDX_IRQ_STAT, 8'h03);
            rreg(PPC_IDX_IRQ_STAT, 8'h00, "cleared");
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_errors();
        t_pullup();
        t_modes();
        t_order();
        t_irq();
        report_and_stop();
    end
endmodule
